// ---- pao_alarm_properties.sv ----
// port checker for the process alarm block
`timescale 1ns/1ps
`default_nettype none
module pao_alarm_properties
(
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // watched ports
    input wire logic       pv_valid,
    input wire logic [4:0] alarm_contact,
    input wire logic       shared_terminal_oe_n,
    input wire logic       front_key_in,
    input wire logic [4:0] event_flag,
    input wire logic [4:0] event_pending,
    input wire logic [2:0] event_top,
    input wire logic       event_top_valid,
    input wire logic       sim_active,
    input wire logic       backlight_on
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic [4:0] prev_ff;
    logic [4:0] chg;
    logic [4:0] lower;
    // flags one cycle back
    always_ff @(posedge clk)
    begin
        prev_ff <= event_flag;
    end
    // changes and pending above the top
    assign chg = event_flag ^ prev_ff;
    assign lower = event_pending & ((5'h01 << event_top) - 5'h01);
    // key press in input mode
    sequence key_press;
        $rose(front_key_in) && shared_terminal_oe_n;
    endsequence
    // light back after sync
    sequence wake;
        ##[1:6] backlight_on;
    endsequence
    reset_state_a: assert property (
        $fell(sys_rst) |-> alarm_contact == 5'h1F && !shared_terminal_oe_n)
        else $error("bad reset state");
    contact_hold_a: assert property (
        !pv_valid |=> $stable(alarm_contact))
        else $error("contacts moved unsampled");
    top_valid_a: assert property (
        !sim_active |-> event_top_valid == (|event_pending))
        else $error("top valid disagrees with pending");
    top_order_a: assert property (
        event_top_valid && !sim_active |->
        event_pending[event_top] && lower == 5'h00)
        else $error("top not highest pending");
    flag_pending_a: assert property (
        (|chg) && !$past(sys_rst) |=> (event_pending & $past(chg)) == $past(chg))
        else $error("flag change not pending");
    key_wake_a: assert property (
        key_press |-> wake)
        else $error("key press left backlight off");
    dark_input_a: assert property (
        $fell(backlight_on) |-> shared_terminal_oe_n)
        else $error("backlight off in output mode");
    shift_one_a: assert property (
        !shared_terminal_oe_n |->
        $onehot0($past(event_pending) & ~event_pending))
        else $error("several events cleared");
endmodule
bind pao_alarm_top pao_alarm_properties u_props
(
    .clk(clk), .sys_rst(sys_rst), .pv_valid(pv_valid),
    .alarm_contact(alarm_contact), .front_key_in(front_key_in),
    .shared_terminal_oe_n(shared_terminal_oe_n), .event_flag(event_flag),
    .event_pending(event_pending), .event_top(event_top),
    .event_top_valid(event_top_valid), .sim_active(sim_active),
    .backlight_on(backlight_on)
);
`default_nettype wire

// ---- pao_alarm_tb_top.sv ----
// self-checking bench for the process alarm block
`timescale 1ns/1ps
`default_nettype none
module pao_alarm_tb_top;
    import pao_pkg::*;
    logic               clk, sys_rst, psel, penable, pwrite, pready, er;
    logic               pslverr, pv_valid, st_in, st_out, st_oe_n, key;
    logic               shift, tv, sim, bl, take, di;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [4:0]         contact, flag, pend;
    logic [2:0]         top;
    logic signed [15:0] pv1, pv2, v1, v2;
    int                 error_cnt, n_checks;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    pao_field_model field
    (
        .clk(clk), .take(take), .v1(v1), .v2(v2), .di_closed(di),
        .pv_valid(pv_valid), .pv1_value(pv1), .pv2_value(pv2),
        .term_out(st_out), .term_oe_n(st_oe_n), .term_in(st_in)
    );
    pao_alarm_top #(.SHIFT_HOLD_CYCLES(20)) dut
    (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pv_valid(pv_valid),
        .pv1_value(pv1), .pv2_value(pv2), .alarm_contact(contact),
        .shared_terminal_in(st_in), .shared_terminal_out(st_out),
        .shared_terminal_oe_n(st_oe_n), .front_key_in(key),
        .shift_key_in(shift), .event_flag(flag), .event_pending(pend),
        .event_top(top), .event_top_valid(tv), .sim_active(sim),
        .backlight_on(bl)
    );
    // verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && i < 20)
        begin
            @(posedge clk);
            i++;
        end
        if (i == 20)
        begin
            error_cnt++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    // two samples: contacts lag one
    task automatic pt(input logic signed [15:0] a, input logic [4:0] e);
        repeat (2)
        begin
            @(posedge clk);
            take <= 1'b1;
            {v1, v2} <= {a, a};
            @(posedge clk);
            take <= 1'b0;
            tick(3);
        end
        chk("contacts", 32'(e), 32'(contact));
    endtask
    // press shift or a key
    task automatic press(input logic s, input int n);
        @(posedge clk);
        {shift, key} <= {s, !s};
        tick(n);
        {shift, key} <= 2'b00;
        tick(8);
    endtask
    // reset values
    task automatic t_reset;
        chk("contacts", 32'h1F, 32'(contact));
        chk("term out", 32'h1, 32'(st_out));
        chk("oe_n", 32'h0, 32'(st_oe_n));
        chk("backlight", 32'h1, 32'(bl));
        rchk(8'h00, 32'h1);
        rchk(8'h04, 32'h000A000A);
        rchk(8'h14, 32'hFFFFFFC1);
        rchk(8'h30, 32'h0);
        rchk(8'h80, 32'h0);
        chk("pslverr", 32'h1, 32'(er));
    endtask
    // routing and the gap
    task automatic t_route;
        logic [7:0]         wa [8] = '{8'h10, 8'h14, 8'h18, 8'h30,
                                       8'h34, 8'h38, 8'h3C, 8'h40};
        logic [31:0]        wd [8] = '{32'h1F4, 32'hC8, 32'h2BC, 32'h280,
                                       32'h3C0, 32'h2A0, 32'h40, 32'h200};
        logic signed [15:0] pv [6] = '{16'sh0258, 16'sh0320, 16'sh0064,
                                       16'sh01F4, 16'sh01EF, 16'sh01E9};
        logic [4:0]         ex [6] = '{5'h0B, 5'h0F, 5'h02, 5'h0B, 5'h0B,
                                       5'h08};
        foreach (wa[i])
            apb(1'b1, wa[i], wd[i]);
        foreach (pv[i])
            pt(pv[i], ex[i]);
        apb(1'b1, 8'h10, 32'h7D0);
        rchk(8'h10, 32'h427);
        apb(1'b1, 8'h14, 32'hFFFFFF00);
        rchk(8'h14, 32'hFFFFFFC1);
        pt(16'sh0427, 5'h08);
        pt(16'shFFC1, 5'h08);
    endtask
    // terminal as input
    task automatic t_input;
        apb(1'b1, 8'h00, 32'h004);
        tick(2);
        chk("oe_n", 32'h1, 32'(st_oe_n));
        flag <= 5'h01;
        tick(3);
        chk("pending", 32'h01, 32'(pend));
        di <= 1'b0;
        tick(8);
        chk("pending", 32'h00, 32'(pend));
        flag <= 5'h05;
        di <= 1'b1;
        tick(8);
        chk("pending", 32'h04, 32'(pend));
        apb(1'b1, 8'h00, 32'h002);
        di <= 1'b0;
        tick(8);
        chk("backlight", 32'h0, 32'(bl));
        press(1'b0, 3);
        chk("backlight", 32'h1, 32'(bl));
        apb(1'b1, 8'h00, 32'h00A);
        di <= 1'b1;
        tick(8);
        chk("backlight", 32'h0, 32'(bl));
        press(1'b0, 3);
        apb(1'b1, 8'h00, 32'h000);
        di <= 1'b0;
        tick(8);
        chk("backlight", 32'h1, 32'(bl));
        apb(1'b1, 8'h00, 32'h001);
    endtask
    // priority and shift clear
    task automatic t_events;
        flag <= 5'h0F;
        tick(3);
        chk("top", 32'h1, 32'(top));
        press(1'b1, 30);
        chk("pending", 32'h0C, 32'(pend));
        press(1'b1, 30);
        chk("top", 32'h3, 32'(top));
        flag <= 5'h0D;
        tick(3);
        chk("pending", 32'h0A, 32'(pend));
    endtask
    // simulation display
    task automatic t_sim;
        logic [31:0] cw [5] = '{32'h221, 32'h231, 32'h231, 32'h221, 32'h201};
        logic [4:0]  ex = 5'b01001;
        foreach (cw[i])
        begin
            apb(1'b1, 8'h00, cw[i]);
            tick(3);
            chk("sim", 32'(ex[i]), 32'(sim));
        end
    endtask
    // main sequence
    initial
    begin
        {clk, psel, penable, pwrite, take, key, shift} = 7'h00;
        {sys_rst, di, paddr, pwdata, flag} = {2'h3, 45'h0};
        {v1, v2, error_cnt, n_checks} = '0;
        tick(4);
        sys_rst <= 1'b0;
        tick(2);
        t_reset();
        t_route();
        t_input();
        t_events();
        t_sim();
        final_report();
    end
endmodule
`default_nettype wire

// ---- pao_alarm_top.sv ----
// process alarm detection, output routing, input and events
//
// Overview of operation
// - six contacts, sixth only in output mode
// - eight-bit mask, left bit loop-1 high
// - mask one includes, zero excludes alarm
// - and or combine of selected alarms
// - polarity: open or closed on alarm
// - four limit detectors per loop
// - setpoints span -6.3 to 106.3 percent
// - parked setpoints never raise an alarm
// - per-loop hysteresis up to 20 percent
// - hysteresis applied as differential gap
// - reset polarity is open on alarm
// - shared terminal is input or output
// - input function none, backlight, clear
// - input active on open or closed
// - any key restores backlight
// - change into the active input level clears all events
// - new events still show after clear
// - five events, event one on top
// - shift held three seconds clears foreground
// - any flag change triggers its event
// - simulation only while stopped, then ends
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pao_alarm_top
#(
    parameter longint SHIFT_HOLD_CYCLES = pao_pkg::PAO_HOLD_CYCLES
)
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // process variables, 0.1 percent units
    input  wire logic               pv_valid,
    input  wire logic signed [15:0] pv1_value,
    input  wire logic signed [15:0] pv2_value,
    // contacts, high means closed
    output logic      [4:0]         alarm_contact,
    // shared terminal
    input  wire logic               shared_terminal_in,
    output logic                    shared_terminal_out,
    output logic                    shared_terminal_oe_n,
    // front panel keys, high while pressed
    input  wire logic               front_key_in,
    input  wire logic               shift_key_in,
    // event flags and display
    input  wire logic [4:0]         event_flag,
    output logic      [4:0]         event_pending,
    output logic      [2:0]         event_top,
    output logic                    event_top_valid,
    output logic                    sim_active,
    output logic                    backlight_on
);
    import pao_pkg::*;

    // clamp a written setpoint
    function automatic logic signed [15:0] clamp_sp(
        input logic [15:0] raw
    );
        logic signed [15:0] v;
        v = $signed(raw);
        if (v < PAO_SP_MIN)
            clamp_sp = PAO_SP_MIN;
        else if (v > PAO_SP_MAX)
            clamp_sp = PAO_SP_MAX;
        else
            clamp_sp = v;
    endfunction

    // clamp a written hysteresis
    function automatic logic [7:0] clamp_hy(input logic [7:0] raw);
        clamp_hy = (raw > PAO_HYST_MAX) ? PAO_HYST_MAX : raw;
    endfunction

    // reset value of setpoint k: highs at max, lows at min
    function automatic logic signed [15:0] sp_reset(input int k);
        sp_reset = ((k % 2) == 0) ? PAO_SP_MAX : PAO_SP_MIN;
    endfunction

    // registers
    logic        [10:0] ctrl_ff;
    logic        [7:0]  hyst1_ff;
    logic        [7:0]  hyst2_ff;
    logic signed [15:0] sp_ff [PAO_NUM_SP];
    logic        [9:0]  out_cfg_ff [PAO_NUM_OUT];
    logic        [31:0] prdata_ff;
    logic               pslverr_ff;
    // apb decode
    logic               setup_ph;
    logic               wr_acc;
    logic               addr_hit;
    logic        [31:0] nxt_rdata;
    // alarms and contacts
    logic        [7:0]  alarm_vec;
    logic        [5:0]  out_active;
    logic        [5:0]  contact_ff;
    // synchronisers: 0 terminal, 1 any key, 2 shift
    logic        [2:0]  sync1_ff;
    logic        [2:0]  sync2_ff;
    logic        [2:0]  prev_ff;
    logic               di_active;
    logic               di_active_ff;
    logic               di_open_edge;
    logic               backlight_ff;
    // events
    logic        [4:0]  flag_prev_ff;
    logic        [4:0]  pend_ff;
    logic        [4:0]  top_onehot;
    logic               clear_all;
    logic               clear_top;
    logic               sim_ff;
    logic               run_prev_ff;
    pao_hold_t          hold_ff;
    logic        [31:0] hold_cnt_ff;
    pao_fn_t            di_fn;

    assign di_fn = pao_fn_t'(ctrl_ff[PAO_CTRL_FN_LSB +: 2]);

    // apb: zero-wait slave, read data captured in setup
    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite;
    assign pready   = 1'b1;
    assign prdata   = prdata_ff;
    assign pslverr  = pslverr_ff;

    // address decode for reads
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        addr_hit  = 1'b1;
        if (paddr == PAO_OFS_CTRL)
            nxt_rdata[10:0] = ctrl_ff;
        else if (paddr == PAO_OFS_HYST)
        begin
            nxt_rdata[PAO_HYST1_LSB +: 8] = hyst1_ff;
            nxt_rdata[PAO_HYST2_LSB +: 8] = hyst2_ff;
        end
        else if (paddr == PAO_OFS_STATUS)
            nxt_rdata[16:0] = {sim_ff, backlight_ff,
                               di_active_ff, contact_ff, alarm_vec};
        else if (paddr == PAO_OFS_EVENT)
            nxt_rdata[13:0] = {event_top_valid, event_top,
                               flag_prev_ff, pend_ff};
        else
            addr_hit = 1'b0;
        for (int k = 0; k < PAO_NUM_SP; k++)
            if (paddr == PAO_OFS_SP_BASE + 8'(4 * k))
            begin
                nxt_rdata = {{16{sp_ff[k][15]}}, sp_ff[k]};
                addr_hit  = 1'b1;
            end
        for (int n = 0; n < PAO_NUM_OUT; n++)
            if (paddr == PAO_OFS_OUT_BASE + 8'(4 * n))
            begin
                nxt_rdata = {22'h00_0000, out_cfg_ff[n]};
                addr_hit  = 1'b1;
            end
    end

    // read data and error held into access
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_rdata;
            pslverr_ff <= ~addr_hit;
        end
    end

    // control and hysteresis registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_ff  <= PAO_CTRL_RST;
            hyst1_ff <= PAO_HYST_RST;
            hyst2_ff <= PAO_HYST_RST;
        end
        else if (wr_acc && paddr == PAO_OFS_CTRL)
            ctrl_ff <= pwdata[10:0];
        else if (wr_acc && paddr == PAO_OFS_HYST)
        begin
            hyst1_ff <= clamp_hy(pwdata[PAO_HYST1_LSB +: 8]);
            hyst2_ff <= clamp_hy(pwdata[PAO_HYST2_LSB +: 8]);
        end
    end

    // setpoints and output configurations
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < PAO_NUM_SP; k++)
                sp_ff[k] <= sp_reset(k);
            // polarity resets to open on alarm
            for (int n = 0; n < PAO_NUM_OUT; n++)
                out_cfg_ff[n] <= PAO_OUT_RST;
        end
        else if (wr_acc)
        begin
            for (int k = 0; k < PAO_NUM_SP; k++)
                if (paddr == PAO_OFS_SP_BASE + 8'(4 * k))
                    sp_ff[k] <= clamp_sp(pwdata[15:0]);
            for (int n = 0; n < PAO_NUM_OUT; n++)
                if (paddr == PAO_OFS_OUT_BASE + 8'(4 * n))
                    out_cfg_ff[n] <= pwdata[9:0];
        end
    end

    // four detectors per loop
    // k even is a high-side detector
    for (genvar k = 0; k < PAO_NUM_SP; k++)
    begin : g_det
        pao_limit_detect u_det
        (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .update    (pv_valid),
            .pv        ((k < 4) ? pv1_value : pv2_value),
            .setpoint  (sp_ff[k]),
            .hyst      ((k < 4) ? hyst1_ff : hyst2_ff),
            .high_side ((k % 2) == 0),
            // leftmost mask bit is loop-1 high
            .alarm     (alarm_vec[7 - k])
        );
    end

    // combine selected alarms per output
    always_comb
    begin
        for (int n = 0; n < PAO_NUM_OUT; n++)
        begin
            // zero bits drop out of the combine
            // or of selected, or and of selected
            if (out_cfg_ff[n][PAO_OUT_OR_BIT])
                out_active[n] = |(alarm_vec & out_cfg_ff[n][7:0]);
            else
                out_active[n] = (out_cfg_ff[n][7:0] != 8'h00) &&
                    (&(alarm_vec | ~out_cfg_ff[n][7:0]));
        end
    end

    // contacts follow each measurement
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            contact_ff <= 6'h3F;
        else if (pv_valid)
            for (int n = 0; n < PAO_NUM_OUT; n++)
                contact_ff[n] <= out_cfg_ff[n][PAO_OUT_POL_BIT] ?
                                 out_active[n] : ~out_active[n];
    end

    assign alarm_contact = contact_ff[4:0];
    // terminal driven only in output mode
    assign shared_terminal_out  = ctrl_ff[PAO_CTRL_SEL_BIT] &
                                  contact_ff[5];
    assign shared_terminal_oe_n = ~ctrl_ff[PAO_CTRL_SEL_BIT];

    // pin synchronisers; edge logic reads the second stage and prev_ff
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff  <= 3'h0;
        end
        else
        begin
            sync1_ff <= {shift_key_in, front_key_in,
                         shared_terminal_in};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // active on closed or on open
    assign di_active = ~ctrl_ff[PAO_CTRL_SEL_BIT] &
        (ctrl_ff[PAO_CTRL_POL_BIT] ? sync2_ff[0] : ~sync2_ff[0]);

    // input function edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            di_active_ff <= 1'b0;
        else
            di_active_ff <= di_active;
    end
    assign di_open_edge = di_active & ~di_active_ff;

    // backlight: input switches off, any key restores
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            backlight_ff <= 1'b1;
        else if (di_fn == PAO_FN_BACKLIGHT && di_open_edge)
            backlight_ff <= 1'b0;
        // one press turns it on again
        else if (sync2_ff[1] && !prev_ff[1])
            backlight_ff <= 1'b1;
    end
    assign backlight_on = backlight_ff;

    // active level leaves new events shown
    assign clear_all = (di_fn == PAO_FN_CLEAR) && di_open_edge;

    // shift hold timer; fires once per press
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            hold_ff     <= PAO_HOLD_IDLE;
            hold_cnt_ff <= 32'h0000_0000;
        end
        else
        begin
            case (hold_ff)
                PAO_HOLD_IDLE:
                begin
                    hold_cnt_ff <= 32'h0000_0001;
                    if (sync2_ff[2])
                        hold_ff <= PAO_HOLD_COUNT;
                end
                PAO_HOLD_COUNT:
                begin
                    hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
                    if (!sync2_ff[2])
                        hold_ff <= PAO_HOLD_IDLE;
                    else if (hold_cnt_ff >=
                             32'(SHIFT_HOLD_CYCLES - 1))
                        hold_ff <= PAO_HOLD_DONE;
                end
                PAO_HOLD_DONE:
                    if (!sync2_ff[2])
                        hold_ff <= PAO_HOLD_IDLE;
                default:
                    hold_ff <= PAO_HOLD_IDLE;
            endcase
        end
    end
    assign clear_top = (hold_ff == PAO_HOLD_COUNT) && sync2_ff[2] &&
                       (hold_cnt_ff >= 32'(SHIFT_HOLD_CYCLES - 1));

    // lowest index pending is the foreground
    assign top_onehot = pend_ff & (~pend_ff + 5'h01);

    // event pending bits; a flag change beats a clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            flag_prev_ff <= 5'h00;
            pend_ff      <= 5'h00;
        end
        else
        begin
            flag_prev_ff <= event_flag;
            pend_ff <= ((clear_all ? 5'h00 : pend_ff) &
                        ~(clear_top ? top_onehot : 5'h00)) |
                       (event_flag ^ flag_prev_ff);
        end
    end

    // set while stopped; off or run ends it
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sim_ff      <= 1'b0;
            run_prev_ff <= 1'b0;
        end
        else
        begin
            run_prev_ff <= ctrl_ff[PAO_CTRL_RUN_BIT];
            if (!ctrl_ff[PAO_CTRL_SIM_BIT] ||
                (ctrl_ff[PAO_CTRL_RUN_BIT] && !run_prev_ff))
                sim_ff <= 1'b0;
            else if (!ctrl_ff[PAO_CTRL_RUN_BIT] &&
                     ctrl_ff[PAO_CTRL_SIMEV_LSB +: 3] <
                     3'(PAO_NUM_EVT))
                sim_ff <= 1'b1;
        end
    end

    // display view; simulation forces its event
    always_comb
    begin
        event_pending   = pend_ff;
        event_top       = 3'h0;
        event_top_valid = |pend_ff;
        for (int e = PAO_NUM_EVT - 1; e >= 0; e--)
            if (pend_ff[e])
                event_top = 3'(e);
        if (sim_ff)
        begin
            event_top       = ctrl_ff[PAO_CTRL_SIMEV_LSB +: 3];
            event_top_valid = 1'b1;
        end
    end
    assign sim_active = sim_ff;
endmodule
`default_nettype wire

// ---- pao_field_model.sv ----
// field side: measurement sampler and terminal wiring
`timescale 1ns/1ps
`default_nettype none
module pao_field_model
(
    // clock
    input  wire logic               clk,
    // bench requests
    input  wire logic               take,
    input  wire logic signed [15:0] v1,
    input  wire logic signed [15:0] v2,
    input  wire logic               di_closed,
    // device side
    output logic                    pv_valid,
    output logic signed [15:0]      pv1_value,
    output logic signed [15:0]      pv2_value,
    input  wire logic               term_out,
    input  wire logic               term_oe_n,
    output logic                    term_in
);
    // one strobe per request; values scrambled outside it
    always @(posedge clk)
    begin
        pv_valid <= take;
        pv1_value <= take ? v1 : ~pv1_value;
        pv2_value <= take ? v2 : ~pv2_value;
    end
    assign term_in = term_oe_n ? di_closed : term_out;
endmodule
`default_nettype wire

// ---- pao_limit_detect.sv ----
// one limit comparator with differential gap
`timescale 1ns/1ps
`default_nettype none
module pao_limit_detect
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // measurement
    input  wire logic               update,
    input  wire logic signed [15:0] pv,
    // settings
    input  wire logic signed [15:0] setpoint,
    input  wire logic        [7:0]  hyst,
    input  wire logic               high_side,
    // result
    output logic                    alarm
);
    import pao_pkg::*;

    logic               alarm_ff;
    logic               disabled;
    logic signed [16:0] pv_x;
    logic signed [16:0] sp_x;
    logic signed [16:0] hy_x;

    // setpoint parked at the range end turns the detector off
    assign disabled = high_side ? (setpoint == PAO_SP_MAX)
                                : (setpoint == PAO_SP_MIN);
    assign pv_x = {pv[15], pv};
    assign sp_x = {setpoint[15], setpoint};
    assign hy_x = {9'h000, hyst};

    // assert on reaching setpoint, release past the gap
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            alarm_ff <= 1'b0;
        else if (disabled)
            alarm_ff <= 1'b0;
        else if (update && high_side)
        begin
            if (pv_x >= sp_x)
                alarm_ff <= 1'b1;
            else if (pv_x < sp_x - hy_x)
                alarm_ff <= 1'b0;
        end
        else if (update)
        begin
            if (pv_x <= sp_x)
                alarm_ff <= 1'b1;
            else if (pv_x > sp_x + hy_x)
                alarm_ff <= 1'b0;
        end
    end

    assign alarm = alarm_ff;
endmodule
`default_nettype wire

// ---- pao_pkg.sv ----
// constants shared by the process alarm output logic
package pao_pkg;
    // register byte offsets
    localparam logic [7:0]  PAO_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  PAO_OFS_HYST    = 8'h04;
    localparam logic [7:0]  PAO_OFS_STATUS  = 8'h08;
    localparam logic [7:0]  PAO_OFS_EVENT   = 8'h0C;
    localparam logic [7:0]  PAO_OFS_SP_BASE = 8'h10;
    localparam logic [7:0]  PAO_OFS_OUT_BASE = 8'h30;
    localparam int          PAO_NUM_SP      = 8;
    localparam int          PAO_NUM_OUT     = 6;
    localparam int          PAO_NUM_EVT     = 5;
    // control register fields
    localparam int          PAO_CTRL_SEL_BIT   = 0;
    localparam int          PAO_CTRL_FN_LSB    = 1;
    localparam int          PAO_CTRL_POL_BIT   = 3;
    localparam int          PAO_CTRL_RUN_BIT   = 4;
    localparam int          PAO_CTRL_SIM_BIT   = 5;
    localparam int          PAO_CTRL_SIMEV_LSB = 8;
    // hysteresis register fields
    localparam int          PAO_HYST1_LSB   = 0;
    localparam int          PAO_HYST2_LSB   = 16;
    // output configuration fields
    localparam int          PAO_OUT_MASK_LSB = 0;
    localparam int          PAO_OUT_OR_BIT   = 8;
    localparam int          PAO_OUT_POL_BIT  = 9;
    // setpoints and hysteresis in units of 0.1 percent of span
    localparam logic signed [15:0] PAO_SP_MIN   = -16'sd63;
    localparam logic signed [15:0] PAO_SP_MAX   = 16'sd1063;
    localparam logic [7:0]         PAO_HYST_MAX = 8'd200;
    // reset values
    localparam logic [10:0] PAO_CTRL_RST = 11'h001;
    localparam logic [7:0]  PAO_HYST_RST = 8'h0A;
    localparam logic [9:0]  PAO_OUT_RST  = 10'h000;
    // shift key hold time
    localparam longint      PAO_CLK_KHZ        = 200000;
    localparam longint      PAO_HOLD_TIME_MS   = 3000;
    localparam longint      PAO_HOLD_CYCLES    =
        (PAO_HOLD_TIME_MS * PAO_CLK_KHZ);
    // digital input function codes
    typedef enum logic [1:0] {
        PAO_FN_NONE      = 2'b00,
        PAO_FN_BACKLIGHT = 2'b01,
        PAO_FN_CLEAR     = 2'b10
    } pao_fn_t;
    // shift hold sequencer
    typedef enum logic [1:0] {
        PAO_HOLD_IDLE  = 2'b00,
        PAO_HOLD_COUNT = 2'b01,
        PAO_HOLD_DONE  = 2'b10
    } pao_hold_t;
endpackage
